// File: pkg/timer_pkg.sv
// constants, field layout and reset values of the 8-bit timer with two compare channels
// assumes a classic wishbone master with 32-bit data; register data sits in bits 7:0
//
// How it works
// - counter, compare A and compare B values are 8-bit software-accessible registers.
// - overflow, compare A and compare B requests are readable bits in the flag register.
// - each request is gated by its own enable bit in the mask register.
// - ticks come from prescaler outputs or the external count input pin.
// - clock source select picks tick source and the active external edge.
// - with no tick source the counter stays still and raises no tick events.
// - both compare values are compared with the counter on every cycle.
// - a compare match sets that channel's compare flag.
// - compare results drive PWM or frequency waveforms on outputs A and B.
// - bottom is a counter value of 0x00.
// - maximum is a counter value of 0xff.
// - top is 0xff or compare A value, depending on mode.
// - tick source is chosen by a three-bit field in control register B.
// - three interrupt sources: overflow, compare A, compare B.
// - two compare channels, each with register, flag and output pin.
// - a clear-on-match mode reloads the counter from zero at top.
// - phase-correct PWM and a variable PWM period are supported.
// - select value zero stops the timer; counter access still works.
// - a software counter write wins over clear or count in that cycle.
// - compare flag sets on the tick after a match; cleared by ack or write one.
// - a counter write blocks compare matches on the next tick, even when stopped.

package timer_pkg;

    // -----------------------------------------------------------------
    // register offsets (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_CMP_A = 8'h04;
    localparam logic [7:0] OFS_CMP_B = 8'h08;
    localparam logic [7:0] OFS_CTRL_A = 8'h0c;
    localparam logic [7:0] OFS_CTRL_B = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int WGM_LSB = 0;
    localparam int COM_B_LSB = 4;
    localparam int COM_A_LSB = 6;
    localparam int CS_LSB = 0;
    localparam int WGM2_BIT = 3;
    localparam int FORCE_B_BIT = 6;
    localparam int FORCE_A_BIT = 7;
    localparam int OVF_BIT = 0;
    localparam int CMP_A_BIT = 1;
    localparam int CMP_B_BIT = 2;

    // -----------------------------------------------------------------
    // values
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL = 8'hff;
    localparam logic [2:0] RST_FLAGS = 3'h0;

    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    localparam logic [9:0] PRE_RST = 10'h000;
    localparam logic [9:0] PRE_M8 = 10'h007;
    localparam logic [9:0] PRE_M64 = 10'h03f;
    localparam logic [9:0] PRE_M256 = 10'h0ff;
    localparam logic [9:0] PRE_M1024 = 10'h3ff;

    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_CTC = 3'h2;

endpackage : timer_pkg

// File: pkg/tick_if.sv
// carrier between the timer core and its tick source selector
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface tick_if;
    logic [2:0] clock_source_select;
    logic timer_tick;
    modport src (input clock_source_select, output timer_tick);
    modport snk (output clock_source_select, input timer_tick);
endinterface : tick_if

// File: core/tick_select.sv
// prescaler and tick source selector for the 8-bit timer
// assumes external_count_input is asynchronous to mclk
`timescale 1ns/1ps

module tick_select (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic external_count_input,
    tick_if.src tk
);

    logic ext_s1_r, ext_s2_r, ext_s3_r;
    logic [9:0] pre_r, pre_nxt;
    logic tick_r, tick_nxt;

    function automatic logic pre_hit(input logic [9:0] p, input logic [9:0] m);
        return (p & m) == m;
    endfunction : pre_hit

    // -----------------------------------------------------------------
    // source choice
    // -----------------------------------------------------------------
    always_comb begin
        pre_nxt = pre_r + 10'h001;
        case (tk.clock_source_select)
            timer_pkg::CS_STOP: tick_nxt = 1'b0;
            timer_pkg::CS_DIV1: tick_nxt = 1'b1;
            timer_pkg::CS_DIV8: tick_nxt = pre_hit(pre_r, timer_pkg::PRE_M8);
            timer_pkg::CS_DIV64: tick_nxt = pre_hit(pre_r, timer_pkg::PRE_M64);
            timer_pkg::CS_DIV256: tick_nxt = pre_hit(pre_r, timer_pkg::PRE_M256);
            timer_pkg::CS_DIV1024: tick_nxt = pre_hit(pre_r, timer_pkg::PRE_M1024);
            timer_pkg::CS_EXT_FALL: tick_nxt = ext_s3_r & ~ext_s2_r;
            timer_pkg::CS_EXT_RISE: tick_nxt = ext_s2_r & ~ext_s3_r;
            default: tick_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            pre_r <= timer_pkg::PRE_RST;
            tick_r <= 1'b0;
        end else begin
            ext_s1_r <= external_count_input;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.timer_tick = tick_r;

    AST_TICK_STOPPED: assert property (@(posedge mclk) disable iff (!rst_n)
        tk.clock_source_select == timer_pkg::CS_STOP |=> !tk.timer_tick)
        else $error("tick seen while source is stopped");

    AST_EXT_RISE_TICK: assert property (@(posedge mclk) disable iff (!rst_n)
        (tk.clock_source_select == timer_pkg::CS_EXT_RISE) && ext_s2_r && !ext_s3_r
        |=> tk.timer_tick)
        else $error("rising external edge gave no tick");

endmodule : tick_select

// File: core/timer8.sv
// 8-bit timer/counter with two compare channels behind a wishbone slave
// assumes a classic wishbone master on mclk; irq_ack comes from logic on mclk
`timescale 1ns/1ps

module timer8 (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic external_count_input,
    input wire logic [2:0] irq_ack,
    output logic compare_a_output,
    output logic compare_b_output,
    output logic timer_irq
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [7:0] count_value_r, count_value_nxt;
    logic [7:0] compare_a_value_r, compare_a_value_nxt;
    logic [7:0] compare_b_value_r, compare_b_value_nxt;
    logic [7:0] buf_a_r, buf_a_nxt, buf_b_r, buf_b_nxt;
    logic [7:0] ctrl_a_r, ctrl_a_nxt;
    logic [3:0] timer_control_b_r, timer_control_b_nxt;
    logic [2:0] timer_flag_reg_r, timer_flag_reg_nxt;
    logic [2:0] timer_mask_reg_r, timer_mask_reg_nxt;
    logic down_r, down_nxt, block_r, block_nxt;
    logic oc_a_r, oc_a_nxt, oc_b_r, oc_b_nxt;
    logic pin_a_r, pin_a_nxt, pin_b_r, pin_b_nxt;
    logic irq_r, irq_nxt, ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;

    logic acc, wr;
    logic [2:0] wgm, set_f, clr_f;
    logic pwm, phase_mode, fast_mode, top_from_a, tick;
    logic [7:0] top_val;
    logic match_a, match_b, hit_a, hit_b, at_top, wrap_bot, load_buf;
    logic [1:0] com_a, com_b;

    tick_if tk ();

    tick_select u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .external_count_input(external_count_input),
        .tk(tk.src)
    );

    function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] o,
                                    input logic s);
        return w && (a == o) && s;
    endfunction : wr_hit

    // waveform step for one channel
    function automatic logic wave_next(input logic [1:0] com, input logic pw, input logic pc,
                                       input logic oc, input logic hit, input logic bot,
                                       input logic dn);
        logic r;
        r = oc;
        if (!pw) begin
            if (hit) begin
                case (com)
                    2'h1: r = ~oc;
                    2'h2: r = 1'b0;
                    2'h3: r = 1'b1;
                    default: r = oc;
                endcase
            end
        end else if (pc) begin
            if (hit && com[1]) begin
                r = com[0] ^ dn;
            end
        end else begin
            if (hit && com[1]) begin
                r = com[0];
            end else if (bot && com[1]) begin
                r = ~com[0];
            end
        end
        return r;
    endfunction : wave_next

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = acc & wb_we_i;
    assign tick = tk.timer_tick;
    assign tk.clock_source_select = timer_control_b_r[timer_pkg::CS_LSB +: 3];
    assign wgm = {timer_control_b_r[timer_pkg::WGM2_BIT], ctrl_a_r[timer_pkg::WGM_LSB +: 2]};
    assign pwm = wgm[0];
    assign phase_mode = wgm[1:0] == 2'h1;
    assign fast_mode = wgm[1:0] == 2'h3;
    assign top_from_a = wgm[2] | (wgm == timer_pkg::WGM_CTC);
    assign top_val = top_from_a ? compare_a_value_r : timer_pkg::MAX_VAL;
    assign com_a = ctrl_a_r[timer_pkg::COM_A_LSB +: 2];
    assign com_b = ctrl_a_r[timer_pkg::COM_B_LSB +: 2];
    assign match_a = count_value_r == compare_a_value_r;
    assign match_b = count_value_r == compare_b_value_r;
    assign at_top = count_value_r == top_val;

    // -----------------------------------------------------------------
    // counter, compare and waveform
    // -----------------------------------------------------------------
    always_comb begin
        count_value_nxt = count_value_r;
        down_nxt = down_r;
        block_nxt = block_r;
        set_f = 3'h0;
        wrap_bot = 1'b0;
        load_buf = 1'b0;
        hit_a = tick & match_a & ~block_r;
        hit_b = tick & match_b & ~block_r;
        if (tick) begin
            block_nxt = 1'b0;
            if (hit_a) begin
                set_f[timer_pkg::CMP_A_BIT] = 1'b1;
            end
            if (hit_b) begin
                set_f[timer_pkg::CMP_B_BIT] = 1'b1;
            end
            if (phase_mode) begin
                if (!down_r && at_top) begin
                    down_nxt = 1'b1;
                    load_buf = 1'b1;
                    count_value_nxt = count_value_r - 8'h01;
                end else if (down_r && count_value_r == timer_pkg::BOTTOM_VAL) begin
                    down_nxt = 1'b0;
                    set_f[timer_pkg::OVF_BIT] = 1'b1;
                    count_value_nxt = count_value_r + 8'h01;
                end else begin
                    count_value_nxt = down_r ? count_value_r - 8'h01 : count_value_r + 8'h01;
                end
            end else if (fast_mode) begin
                down_nxt = 1'b0;
                if (at_top) begin
                    count_value_nxt = timer_pkg::BOTTOM_VAL;
                    set_f[timer_pkg::OVF_BIT] = 1'b1;
                    wrap_bot = 1'b1;
                    load_buf = 1'b1;
                end else begin
                    count_value_nxt = count_value_r + 8'h01;
                end
            end else begin
                down_nxt = 1'b0;
                if (count_value_r == timer_pkg::MAX_VAL) begin
                    set_f[timer_pkg::OVF_BIT] = 1'b1;
                end
                if (top_from_a && at_top) begin
                    count_value_nxt = timer_pkg::BOTTOM_VAL;
                end else begin
                    count_value_nxt = count_value_r + 8'h01;
                end
            end
        end
        if (wr_hit(wr, wb_adr_i, timer_pkg::OFS_COUNT, wb_sel_i[0])) begin
            count_value_nxt = wb_dat_i[7:0];
            block_nxt = 1'b1;
        end
        oc_a_nxt = wave_next(com_a, pwm, phase_mode, oc_a_r, hit_a, wrap_bot, down_r);
        oc_b_nxt = wave_next(com_b, pwm, phase_mode, oc_b_r, hit_b, wrap_bot, down_r);
        if (!pwm && wr_hit(wr, wb_adr_i, timer_pkg::OFS_CTRL_B, wb_sel_i[0])) begin
            oc_a_nxt = wave_next(com_a, 1'b0, 1'b0, oc_a_nxt,
                                 wb_dat_i[timer_pkg::FORCE_A_BIT], 1'b0, 1'b0);
            oc_b_nxt = wave_next(com_b, 1'b0, 1'b0, oc_b_nxt,
                                 wb_dat_i[timer_pkg::FORCE_B_BIT], 1'b0, 1'b0);
        end
        pin_a_nxt = (com_a != 2'h0) & oc_a_r;
        pin_b_nxt = (com_b != 2'h0) & oc_b_r;
    end

    // -----------------------------------------------------------------
    // registers seen by software
    // -----------------------------------------------------------------
    always_comb begin
        buf_a_nxt = buf_a_r;
        buf_b_nxt = buf_b_r;
        compare_a_value_nxt = load_buf ? buf_a_r : compare_a_value_r;
        compare_b_value_nxt = load_buf ? buf_b_r : compare_b_value_r;
        ctrl_a_nxt = ctrl_a_r;
        timer_control_b_nxt = timer_control_b_r;
        timer_mask_reg_nxt = timer_mask_reg_r;
        clr_f = irq_ack;
        if (wr_hit(wr, wb_adr_i, timer_pkg::OFS_CMP_A, wb_sel_i[0])) begin
            buf_a_nxt = wb_dat_i[7:0];
            if (!pwm) begin
                compare_a_value_nxt = wb_dat_i[7:0];
            end
        end
        if (wr_hit(wr, wb_adr_i, timer_pkg::OFS_CMP_B, wb_sel_i[0])) begin
            buf_b_nxt = wb_dat_i[7:0];
            if (!pwm) begin
                compare_b_value_nxt = wb_dat_i[7:0];
            end
        end
        if (wr_hit(wr, wb_adr_i, timer_pkg::OFS_CTRL_A, wb_sel_i[0])) begin
            ctrl_a_nxt = wb_dat_i[7:0];
        end
        if (wr_hit(wr, wb_adr_i, timer_pkg::OFS_CTRL_B, wb_sel_i[0])) begin
            timer_control_b_nxt = wb_dat_i[3:0];
        end
        if (wr_hit(wr, wb_adr_i, timer_pkg::OFS_MASK, wb_sel_i[0])) begin
            timer_mask_reg_nxt = wb_dat_i[2:0];
        end
        if (wr_hit(wr, wb_adr_i, timer_pkg::OFS_FLAG, wb_sel_i[0])) begin
            clr_f = clr_f | wb_dat_i[2:0];
        end
        timer_flag_reg_nxt = (timer_flag_reg_r & ~clr_f) | set_f;
        irq_nxt = |(timer_flag_reg_r & timer_mask_reg_r);
        ack_nxt = acc;
        dat_nxt = 32'h0000_0000;
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                timer_pkg::OFS_COUNT: dat_nxt[7:0] = count_value_r;
                timer_pkg::OFS_CMP_A: dat_nxt[7:0] = pwm ? buf_a_r : compare_a_value_r;
                timer_pkg::OFS_CMP_B: dat_nxt[7:0] = pwm ? buf_b_r : compare_b_value_r;
                timer_pkg::OFS_CTRL_A: dat_nxt[7:0] = ctrl_a_r;
                timer_pkg::OFS_CTRL_B: dat_nxt[3:0] = timer_control_b_r;
                timer_pkg::OFS_FLAG: dat_nxt[2:0] = timer_flag_reg_r;
                timer_pkg::OFS_MASK: dat_nxt[2:0] = timer_mask_reg_r;
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_value_r <= timer_pkg::RST_BYTE;
            compare_a_value_r <= timer_pkg::RST_BYTE;
            compare_b_value_r <= timer_pkg::RST_BYTE;
            buf_a_r <= timer_pkg::RST_BYTE;
            buf_b_r <= timer_pkg::RST_BYTE;
            ctrl_a_r <= timer_pkg::RST_BYTE;
            timer_control_b_r <= 4'h0;
            timer_flag_reg_r <= timer_pkg::RST_FLAGS;
            timer_mask_reg_r <= timer_pkg::RST_FLAGS;
            down_r <= 1'b0;
            block_r <= 1'b0;
            oc_a_r <= 1'b0;
            oc_b_r <= 1'b0;
            pin_a_r <= 1'b0;
            pin_b_r <= 1'b0;
            irq_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            count_value_r <= count_value_nxt;
            compare_a_value_r <= compare_a_value_nxt;
            compare_b_value_r <= compare_b_value_nxt;
            buf_a_r <= buf_a_nxt;
            buf_b_r <= buf_b_nxt;
            ctrl_a_r <= ctrl_a_nxt;
            timer_control_b_r <= timer_control_b_nxt;
            timer_flag_reg_r <= timer_flag_reg_nxt;
            timer_mask_reg_r <= timer_mask_reg_nxt;
            down_r <= down_nxt;
            block_r <= block_nxt;
            oc_a_r <= oc_a_nxt;
            oc_b_r <= oc_b_nxt;
            pin_a_r <= pin_a_nxt;
            pin_b_r <= pin_b_nxt;
            irq_r <= irq_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign compare_a_output = pin_a_r;
    assign compare_b_output = pin_b_r;
    assign timer_irq = irq_r;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence count_write;
        wr && wb_adr_i == timer_pkg::OFS_COUNT && wb_sel_i[0];
    endsequence

    sequence quiet_count;
        !tick && !(wr && wb_adr_i == timer_pkg::OFS_COUNT);
    endsequence

    AST_STOPPED_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n)
        tk.clock_source_select == timer_pkg::CS_STOP ##1 quiet_count
        |=> $stable(count_value_r))
        else $error("counter moved while stopped");

    AST_WRITE_WINS: assert property (@(posedge mclk) disable iff (!rst_n)
        count_write |=> count_value_r == $past(wb_dat_i[7:0]))
        else $error("counter write lost");

    AST_FLAG_A_SET: assert property (@(posedge mclk) disable iff (!rst_n)
        tick && match_a && !block_r |=> timer_flag_reg_r[timer_pkg::CMP_A_BIT])
        else $error("compare A flag not set after match");

    AST_BLOCK_MATCH: assert property (@(posedge mclk) disable iff (!rst_n)
        count_write ##1 (tick && !timer_flag_reg_r[timer_pkg::CMP_B_BIT])
        |=> !timer_flag_reg_r[timer_pkg::CMP_B_BIT])
        else $error("match not blocked after counter write");

    AST_IRQ_GATED: assert property (@(posedge mclk) disable iff (!rst_n)
        timer_irq == $past(|(timer_flag_reg_r & timer_mask_reg_r)))
        else $error("interrupt not gated by mask");

    AST_NORMAL_WRAP: assert property (@(posedge mclk) disable iff (!rst_n)
        wgm == timer_pkg::WGM_NORMAL && tick && count_value_r == timer_pkg::MAX_VAL
        && !acc |=> count_value_r == timer_pkg::BOTTOM_VAL && timer_flag_reg_r[0])
        else $error("normal mode wrap wrong");

    AST_CTC_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
        wgm == timer_pkg::WGM_CTC && tick && match_a && !acc
        |=> count_value_r == timer_pkg::BOTTOM_VAL)
        else $error("clear on match failed");

    AST_PC_TURN: assert property (@(posedge mclk) disable iff (!rst_n)
        phase_mode && tick && at_top && !down_r |=> down_r)
        else $error("phase correct turn missed");

    AST_DIRECT_CMP: assert property (@(posedge mclk) disable iff (!rst_n)
        !pwm && wr && wb_adr_i == timer_pkg::OFS_CMP_A && wb_sel_i[0]
        |=> compare_a_value_r == $past(wb_dat_i[7:0]))
        else $error("non-PWM compare write not direct");

    AST_ACK_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

endmodule : timer8

// File: verification/tb_top.sv
// self-checking bench for the 8-bit timer behind its wishbone slave
// assumes the register map and tick select codes of timer_pkg
`timescale 1ns/1ps

module tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, oca, ocb, irq;
    logic ext = 1'b0;
    logic [2:0] iack = 3'h0;
    logic [7:0] rnd = 8'h10;
    logic [7:0] q;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int div[4] = '{8, 64, 256, 1024};

    always #2.5 mclk = ~mclk;

    timer8 dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .external_count_input(ext), .irq_ack(iack), .compare_a_output(oca),
        .compare_b_output(ocb), .timer_irq(irq));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; read data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= {24'h000000, d};
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wb(1'b1, 8'(4 * (i % 3)), rnd);
            rd(8'(4 * (i % 3)), rnd);
        end
        wb(1'b1, timer_pkg::OFS_CMP_A, 8'h10);
        wb(1'b1, timer_pkg::OFS_CMP_B, 8'h20);
        wb(1'b1, timer_pkg::OFS_COUNT, 8'hf0);
        wb(1'b1, timer_pkg::OFS_CTRL_B, {5'h00, timer_pkg::CS_DIV1});
        idle(60);
        wb(1'b1, timer_pkg::OFS_CTRL_B, 8'h00);
        rd(timer_pkg::OFS_FLAG, 8'h07);
        wb(1'b1, timer_pkg::OFS_MASK, 8'h02);
        idle(2);
        chk({7'h00, irq}, 8'h01);
        wb(1'b1, timer_pkg::OFS_MASK, 8'h00);
        idle(2);
        chk({7'h00, irq}, 8'h00);
        iack <= 3'h1;
        @(posedge mclk);
        iack <= 3'h0;
        wb(1'b1, timer_pkg::OFS_FLAG, 8'h02);
        rd(timer_pkg::OFS_FLAG, 8'h04);
        wb(1'b1, timer_pkg::OFS_FLAG, 8'h04);
        // counter written equal to compare A: the first tick must not match
        wb(1'b1, timer_pkg::OFS_CMP_A, 8'h40);
        wb(1'b1, timer_pkg::OFS_COUNT, 8'h40);
        wb(1'b1, timer_pkg::OFS_CTRL_B, {5'h00, timer_pkg::CS_DIV1});
        idle(20);
        wb(1'b1, timer_pkg::OFS_CTRL_B, 8'h00);
        rd(timer_pkg::OFS_FLAG, 8'h00);
        // clear on match: the count never passes compare A
        wb(1'b1, timer_pkg::OFS_CTRL_A, {5'h00, timer_pkg::WGM_CTC});
        wb(1'b1, timer_pkg::OFS_CMP_A, 8'h08);
        wb(1'b1, timer_pkg::OFS_COUNT, 8'h00);
        wb(1'b1, timer_pkg::OFS_CTRL_B, {5'h00, timer_pkg::CS_DIV1});
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            idle(int'(rnd[3:0]));
            wb(1'b0, timer_pkg::OFS_COUNT, 8'h00);
            chk({7'h00, q > 8'h08}, 8'h00);
        end
        wb(1'b1, timer_pkg::OFS_CTRL_B, 8'h00);
        wb(1'b1, timer_pkg::OFS_CTRL_A, 8'h00);
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, timer_pkg::OFS_COUNT, 8'h00);
            wb(1'b1, timer_pkg::OFS_CTRL_B, {5'h00, m ? timer_pkg::CS_EXT_FALL
                : timer_pkg::CS_EXT_RISE});
            repeat (10) begin
                idle(8);
                ext <= 1'b1;
                idle(8);
                ext <= 1'b0;
            end
            idle(8);
            rd(timer_pkg::OFS_COUNT, 8'h0a);
        end
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, timer_pkg::OFS_CTRL_B, 8'h00);
            wb(1'b1, timer_pkg::OFS_COUNT, 8'h00);
            wb(1'b1, timer_pkg::OFS_CTRL_B, {5'h00, timer_pkg::CS_DIV8 + 3'(k)});
            idle(4 * div[k]);
            wb(1'b1, timer_pkg::OFS_CTRL_B, 8'h00);
            wb(1'b0, timer_pkg::OFS_COUNT, 8'h00);
            chk({7'h00, q >= 8'h03 && q <= 8'h05}, 8'h01);
            rd(timer_pkg::OFS_COUNT, q);
        end
        // fast pwm: compare B write stays in its buffer, active B is still 0x20
        wb(1'b1, timer_pkg::OFS_CTRL_A, 8'h03);
        wb(1'b1, timer_pkg::OFS_CMP_B, 8'h05);
        wb(1'b1, timer_pkg::OFS_COUNT, 8'h00);
        wb(1'b1, timer_pkg::OFS_FLAG, 8'h07);
        wb(1'b1, timer_pkg::OFS_CTRL_B, {5'h00, timer_pkg::CS_DIV1});
        idle(20);
        wb(1'b1, timer_pkg::OFS_CTRL_B, 8'h00);
        rd(timer_pkg::OFS_FLAG, 8'h02);
        // force strobes in normal mode: A set on match, B toggles
        wb(1'b1, timer_pkg::OFS_CTRL_A, 8'hd0);
        wb(1'b1, timer_pkg::OFS_CTRL_B, 8'hc0);
        idle(2);
        chk({6'h00, oca, ocb}, 8'h03);
        wb(1'b1, timer_pkg::OFS_CTRL_A, 8'h00);
        idle(2);
        chk({6'h00, oca, ocb}, 8'h00);
        end_of_test();
    end
endmodule : tb_top
